// ==== rtl/mtpbc_map.vh ====
`ifndef MTPBC_MAP_VH
`define MTPBC_MAP_VH
// ****************************************
// Host command codes
// ****************************************
`define MTPBC_CMD_READ      3'h0
`define MTPBC_CMD_WRITE     3'h1
`define MTPBC_CMD_IDREAD    3'h2
`define MTPBC_CMD_RESET     3'h3
`define MTPBC_CMD_STANDBY   3'h4
`define MTPBC_CMD_PROGRAM   3'h5
`define MTPBC_CMD_AUTOSEL   3'h6
// ****************************************
// Command sequence values
// ****************************************
`define MTPBC_UNLOCK1_ADDR  21'h000555
`define MTPBC_UNLOCK2_ADDR  21'h0002AA
`define MTPBC_UNLOCK1_DATA  16'h00AA
`define MTPBC_UNLOCK2_DATA  16'h0055
`define MTPBC_PROG_DATA     16'h00A0
`define MTPBC_AUTOSEL_DATA  16'h0090
`define MTPBC_ID_A9_BIT     9
`define MTPBC_ID_A6_BIT     6
`define MTPBC_LOCK_BIT      7
// ****************************************
// Timing in ns at a 10 ns clock
// ****************************************
`define MTPBC_CLK_NS        10
`define MTPBC_ACCESS_NS     90
`define MTPBC_RESET_NS      500
`define MTPBC_WRPULSE_NS    50
`define MTPBC_ACCESS_CYC    ((`MTPBC_ACCESS_NS+`MTPBC_CLK_NS-1)/`MTPBC_CLK_NS)
`define MTPBC_RESET_CYC     ((`MTPBC_RESET_NS+`MTPBC_CLK_NS-1)/`MTPBC_CLK_NS)
`define MTPBC_WRPULSE_CYC   ((`MTPBC_WRPULSE_NS+`MTPBC_CLK_NS-1)/`MTPBC_CLK_NS)
`endif

// ==== rtl/mtpbc_host.v ====
// What this block does
// - Read: chip select and output enable low, write enable high.
// - Write: write enable and chip select low, output enable high.
// - Host returns to idle after reset and does not restart an aborted operation.
// - ID read: high voltage on A9, A6 low, A1 and A0 from the command address select code.
// - Program: two unlocks, A0 setup, then address and data.
`include "mtpbc_map.vh"
`default_nettype none
module mtpbc_host #(
   parameter AW = 21,
   parameter DW = 16
) (
   input  wire          core_clk_in,
   input  wire          rst_in,
   input  wire          cmd_valid_in,
   input  wire [2:0]    cmd_op_in,
   input  wire [AW-1:0] cmd_addr_in,
   input  wire [DW-1:0] cmd_data_in,
   input  wire          accel_req_in,
   output reg           cmd_ready_out,
   output reg           rsp_valid_out,
   output reg  [DW-1:0] rsp_data_out,
   output reg           rsp_locked_out,
   output reg  [AW-1:0] mem_addr_out,
   output reg           chip_select_n_out,
   output reg           output_enable_n_out,
   output reg           write_enable_n_out,
   output reg           reset_n_out,
   output reg           id_high_voltage_out,
   output reg           accel_program_pin_out,
   input  wire [DW-1:0] mem_data_in,
   output reg  [DW-1:0] mem_data_out,
   output reg           mem_data_oe_out
);
   // ****************************************
   // States
   // ****************************************
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_READ  = 3'h1;
   localparam [2:0] ST_WLOW  = 3'h2;
   localparam [2:0] ST_WHIGH = 3'h3;
   localparam [2:0] ST_RST   = 3'h4;
   localparam [2:0] ST_DONE  = 3'h5;
   // Counts are worked out as integers and cut to the counter width here.
   localparam integer ACCESS_CYC_I = `MTPBC_ACCESS_CYC;
   localparam integer RST_CYC_I    = `MTPBC_RESET_CYC;
   localparam integer WR_CYC_I     = `MTPBC_WRPULSE_CYC;
   localparam [7:0]   ACCESS_CYC   = ACCESS_CYC_I[7:0];
   localparam [7:0]   RST_CYC      = RST_CYC_I[7:0];
   localparam [7:0]   WR_CYC       = WR_CYC_I[7:0];

   reg [2:0]    state_r;
   reg [7:0]    cnt_r;
   reg [1:0]    seq_r;
   reg [1:0]    seq_len_r;
   reg [AW-1:0] tgt_addr_r;
   reg [DW-1:0] tgt_data_r;
   reg          is_id_r;

   // Address and data for one step of a multi-cycle command sequence.
   reg [AW-1:0] step_addr;
   reg [DW-1:0] step_data;
   always @* begin
      step_addr = tgt_addr_r;
      step_data = tgt_data_r;
      case (seq_r)
         2'h0: begin
            step_addr = `MTPBC_UNLOCK1_ADDR;
            step_data = `MTPBC_UNLOCK1_DATA;
         end
         2'h1: begin
            step_addr = `MTPBC_UNLOCK2_ADDR;
            step_data = `MTPBC_UNLOCK2_DATA;
         end
         2'h2: begin
            step_addr = `MTPBC_UNLOCK1_ADDR;
            step_data = (seq_len_r == 2'h3) ? `MTPBC_PROG_DATA
                                           : `MTPBC_AUTOSEL_DATA;
         end
         default: begin
            step_addr = tgt_addr_r;
            step_data = tgt_data_r;
         end
      endcase
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         state_r               <= ST_IDLE;
         cnt_r                 <= 8'h00;
         seq_r                 <= 2'h0;
         seq_len_r             <= 2'h0;
         tgt_addr_r            <= {AW{1'b0}};
         tgt_data_r            <= {DW{1'b0}};
         is_id_r               <= 1'b0;
         cmd_ready_out         <= 1'b0;
         rsp_valid_out         <= 1'b0;
         rsp_data_out          <= {DW{1'b0}};
         rsp_locked_out        <= 1'b0;
         mem_addr_out          <= {AW{1'b0}};
         chip_select_n_out     <= 1'b1;
         output_enable_n_out   <= 1'b1;
         write_enable_n_out    <= 1'b1;
         reset_n_out           <= 1'b1;
         id_high_voltage_out   <= 1'b0;
         accel_program_pin_out <= 1'b0;
         mem_data_out          <= {DW{1'b0}};
         mem_data_oe_out       <= 1'b0;
      end else begin
         rsp_valid_out <= 1'b0;
         accel_program_pin_out <= accel_req_in;
         case (state_r)
            ST_IDLE: begin
               cmd_ready_out <= 1'b1;
               if (cmd_valid_in && cmd_ready_out) begin
                  cmd_ready_out <= 1'b0;
                  tgt_addr_r    <= cmd_addr_in;
                  tgt_data_r    <= cmd_data_in;
                  cnt_r         <= 8'h00;
                  is_id_r       <= 1'b0;
                  case (cmd_op_in)
                     // Array read cycle; from standby too.
                     `MTPBC_CMD_READ: begin
                        mem_addr_out        <= cmd_addr_in;
                        chip_select_n_out   <= 1'b0;
                        output_enable_n_out <= 1'b0;
                        state_r             <= ST_READ;
                     end
                     // High voltage ID read, A6 low, A1 and A0 from the command address.
                     `MTPBC_CMD_IDREAD: begin
                        mem_addr_out <= {{(AW-2){1'b0}},
                                         cmd_addr_in[1:0]};
                        mem_addr_out[`MTPBC_ID_A9_BIT] <= 1'b1;
                        id_high_voltage_out <= 1'b1;
                        chip_select_n_out   <= 1'b0;
                        output_enable_n_out <= 1'b0;
                        is_id_r             <= 1'b1;
                        state_r             <= ST_READ;
                     end
                     // Reset pulse held one cycle past the minimum time.
                     `MTPBC_CMD_RESET: begin
                        reset_n_out <= 1'b0;
                        state_r     <= ST_RST;
                     end
                     `MTPBC_CMD_STANDBY: begin
                        chip_select_n_out <= 1'b1;
                        state_r           <= ST_DONE;
                     end
                     `MTPBC_CMD_PROGRAM: begin
                        seq_r     <= 2'h0;
                        seq_len_r <= 2'h3;
                        state_r   <= ST_WLOW;
                     end
                     // Autoselect entry sequence of three writes.
                     `MTPBC_CMD_AUTOSEL: begin
                        seq_r     <= 2'h0;
                        seq_len_r <= 2'h2;
                        state_r   <= ST_WLOW;
                     end
                     default: begin
                        seq_r     <= 2'h3;
                        seq_len_r <= 2'h3;
                        state_r   <= ST_WLOW;
                     end
                  endcase
               end
            end
            ST_READ: begin
               // Address held stable through the access time.
               cnt_r <= cnt_r + 8'h01;
               if (cnt_r == ACCESS_CYC) begin
                  rsp_data_out        <= mem_data_in;
                  // Lock indicator on an ID read.
                  rsp_locked_out      <= is_id_r & tgt_addr_r[0] &
                                         tgt_addr_r[1] &
                                         mem_data_in[`MTPBC_LOCK_BIT];
                  rsp_valid_out       <= 1'b1;
                  output_enable_n_out <= 1'b1;
                  id_high_voltage_out <= 1'b0;
                  mem_addr_out[`MTPBC_ID_A9_BIT] <=
                     is_id_r ? 1'b0 : mem_addr_out[`MTPBC_ID_A9_BIT];
                  state_r             <= ST_IDLE;
               end
            end
            ST_WLOW: begin
               // Output enable high, chip select low, then write enable low from the second cycle.
               output_enable_n_out <= 1'b1;
               chip_select_n_out   <= 1'b0;
               mem_addr_out        <= step_addr;
               mem_data_out        <= step_data;
               mem_data_oe_out     <= 1'b1;
               cnt_r               <= cnt_r + 8'h01;
               if (cnt_r == 8'h01)
                  write_enable_n_out <= 1'b0;
               // Data held until after the rising strobe.
               if (cnt_r == WR_CYC + 8'h01) begin
                  write_enable_n_out <= 1'b1;
                  cnt_r              <= 8'h00;
                  state_r            <= ST_WHIGH;
               end
            end
            ST_WHIGH: begin
               cnt_r <= cnt_r + 8'h01;
               if (cnt_r == 8'h01) begin
                  mem_data_oe_out <= 1'b0;
                  cnt_r           <= 8'h00;
                  // The command ends once seq_r reaches seq_len_r; a plain write issues only the target step.
                  if (seq_r == seq_len_r) begin
                     rsp_valid_out <= 1'b1;
                     state_r       <= ST_IDLE;
                  end else begin
                     seq_r   <= seq_r + 2'h1;
                     state_r <= ST_WLOW;
                  end
               end
            end
            ST_RST: begin
               // Release with no extra recovery wait.
               cnt_r <= cnt_r + 8'h01;
               if (cnt_r == RST_CYC) begin
                  // Ready returns at once; aborted work is not reissued.
                  reset_n_out   <= 1'b1;
                  rsp_valid_out <= 1'b1;
                  state_r       <= ST_IDLE;
               end
            end
            ST_DONE: begin
               rsp_valid_out <= 1'b1;
               state_r       <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== tb/mtpbc_dev.sv ====
`default_nettype none
module mtpbc_dev #(
   parameter logic [15:0] MFR_ID = 16'h005A,
   parameter logic [15:0] DEV_ID = 16'h1357,
   parameter logic        LOCKED = 1'b1
) (
   input  wire logic [20:0] a_in,
   input  wire logic        cs_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        we_n_in,
   input  wire logic        rst_n_in,
   input  wire logic        idv_in,
   input  wire logic        accel_in,
   input  wire logic [15:0] d_in,
   output logic      [15:0] q_out,
   output logic             q_en_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Device model; identity codes are arbitrary.
   // ****************************************
   logic [15:0] mem [0:15];
   logic [1:0]  step_r;
   logic        asel_r;
   logic        accel_mode;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
      step_r = 2'h0;
      asel_r = 1'b0;
   end
   assign accel_mode = accel_in;
   always @(negedge rst_n_in) begin
      step_r = 2'h0;
      asel_r = 1'b0;
   end
   always @(posedge we_n_in) begin
      if (!cs_n_in && oe_n_in && rst_n_in) begin
         if (step_r == 2'h3) begin
            mem[a_in[3:0]] = d_in;
            step_r = 2'h0;
         end
         else if (step_r == 2'h0 && a_in == 21'h555 && d_in == 16'h00AA)
            step_r = 2'h1;
         else if (step_r == 2'h1 && a_in == 21'h2AA && d_in == 16'h0055)
            step_r = 2'h2;
         else if (step_r == 2'h2 && a_in == 21'h555 && d_in == 16'h00A0)
            step_r = 2'h3;
         else if (step_r == 2'h2 && a_in == 21'h555 && d_in == 16'h0090) begin
            asel_r = 1'b1;
            step_r = 2'h0;
         end
         else begin
            step_r = 2'h0;
            asel_r = 1'b0;
         end
      end
   end
   assign q_out = idv_in ? (a_in[1] ? {8'h00, LOCKED, 7'h08}
                                    : (a_in[0] ? DEV_ID : MFR_ID))
                : asel_r ? (a_in[0] ? DEV_ID : MFR_ID)
                : mem[a_in[3:0]];
   assign q_en_out = !cs_n_in && !oe_n_in && we_n_in && rst_n_in;
endmodule
`default_nettype wire

// ==== tb/mtpbc_host_chk.sv ====
`default_nettype none
module mtpbc_host_chk #(
   parameter AW = 21,
   parameter DW = 16
) (
   input wire logic          core_clk_in,
   input wire logic          rst_in,
   input wire logic          accel_req_in,
   input wire logic          rsp_valid_out,
   input wire logic [AW-1:0] mem_addr_out,
   input wire logic          chip_select_n_out,
   input wire logic          output_enable_n_out,
   input wire logic          write_enable_n_out,
   input wire logic          reset_n_out,
   input wire logic          id_high_voltage_out,
   input wire logic          accel_program_pin_out,
   input wire logic [DW-1:0] mem_data_out,
   input wire logic          mem_data_oe_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Bus checks
   // ****************************************
   logic [7:0] rlo_r;
   always @(posedge core_clk_in) begin
      if (rst_in || reset_n_out) rlo_r <= 8'h00;
      else if (rlo_r != 8'hFF) rlo_r <= rlo_r + 8'h01;
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence rd_start;
      $fell(output_enable_n_out) && write_enable_n_out;
   endsequence
   sequence wr_start;
      $fell(write_enable_n_out);
   endsequence
   chk_read_access:
      assert property (rd_start |-> !output_enable_n_out[*8] ##[1:4]
         rsp_valid_out) else $error("read answer late");
   chk_reset_pulse:
      assert property ($rose(reset_n_out) |-> rlo_r >= 8'h32)
         else $error("reset pulse short");
   chk_we_pulse:
      assert property (wr_start |-> !write_enable_n_out[*5])
         else $error("write pulse short");
   chk_write_hold:
      assert property (!write_enable_n_out |-> mem_data_oe_out &&
         $stable(mem_data_out) && $stable(mem_addr_out))
         else $error("write data moved");
   chk_write_strobes:
      assert property (!write_enable_n_out |-> output_enable_n_out &&
         !chip_select_n_out) else $error("bad write strobes");
   chk_no_contention:
      assert property (!output_enable_n_out |-> !mem_data_oe_out &&
         write_enable_n_out) else $error("bus contention");
   chk_accel_follow:
      assert property ($changed(accel_req_in) |=>
         accel_program_pin_out == $past(accel_req_in))
         else $error("accel pin lag");
   chk_id_address:
      assert property (id_high_voltage_out && !output_enable_n_out |->
         !mem_addr_out[6] && !chip_select_n_out) else $error("bad id read");
endmodule
bind mtpbc_host mtpbc_host_chk #(.AW(AW), .DW(DW)) chk (.core_clk_in,
   .rst_in, .accel_req_in, .rsp_valid_out, .mem_addr_out, .chip_select_n_out,
   .output_enable_n_out, .write_enable_n_out, .reset_n_out,
   .id_high_voltage_out, .accel_program_pin_out, .mem_data_out,
   .mem_data_oe_out);
`default_nettype wire

// ==== tb/mtpbc_host_tb.sv ====
`default_nettype none
module mtpbc_host_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        cmd_valid_in = 1'b0;
   logic [2:0]  cmd_op_in = 3'h0;
   logic [20:0] cmd_addr_in = 21'h000000;
   logic [15:0] cmd_data_in = 16'h0000;
   logic        accel_req_in = 1'b0;
   logic        cmd_ready_out, rsp_valid_out, rsp_locked_out, dev_en;
   logic        chip_select_n_out, output_enable_n_out, write_enable_n_out;
   logic        reset_n_out, id_high_voltage_out, accel_program_pin_out;
   logic        mem_data_oe_out;
   logic [20:0] mem_addr_out;
   logic [15:0] rsp_data_out, mem_data_out, mem_data_in, dev_q;
   logic [15:0] cyc = 16'h0000;
   int          err_count = 0;
   int          checked = 0;
   always #5 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) cyc <= cyc + 16'h0001;
   // A released bus shows a pattern that moves every cycle.
   assign mem_data_in = mem_data_oe_out ? mem_data_out
                                        : (dev_en ? dev_q : cyc);
   mtpbc_host uut (.core_clk_in, .rst_in, .cmd_valid_in, .cmd_op_in,
      .cmd_addr_in, .cmd_data_in, .accel_req_in, .cmd_ready_out,
      .rsp_valid_out, .rsp_data_out, .rsp_locked_out, .mem_addr_out,
      .chip_select_n_out, .output_enable_n_out, .write_enable_n_out,
      .reset_n_out, .id_high_voltage_out, .accel_program_pin_out,
      .mem_data_in, .mem_data_out, .mem_data_oe_out);
   mtpbc_dev dev (.a_in(mem_addr_out), .cs_n_in(chip_select_n_out),
      .oe_n_in(output_enable_n_out), .we_n_in(write_enable_n_out),
      .rst_n_in(reset_n_out), .idv_in(id_high_voltage_out),
      .accel_in(accel_program_pin_out), .d_in(mem_data_in), .q_out(dev_q),
      .q_en_out(dev_en));
   task automatic conclude;
      $display("mismatches %0d of %0d checks", err_count, checked);
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [2:0] op, input logic [20:0] a,
                      input logic [15:0] d);
      int n;
      n = 0;
      cmd_valid_in <= 1'b1;
      cmd_op_in <= op;
      cmd_addr_in <= a;
      cmd_data_in <= d;
      do begin @(posedge core_clk_in); n++; end
      while (cmd_ready_out !== 1'b1 && n < 2000);
      cmd_valid_in <= 1'b0;
      while (rsp_valid_out !== 1'b1 && n < 2000) begin
         @(posedge core_clk_in);
         n++;
      end
      if (n >= 2000) begin
         err_count++;
         conclude();
      end
   endtask
   task automatic rd(input logic [20:0] a, input logic [15:0] exp);
      cmd(3'h0, a, 16'h0000);
      check(rsp_data_out, exp);
   endtask
   task automatic t_array;
      rd(21'h3, 16'h1003);
      rd(21'h4, 16'h1004);
   endtask
   task automatic t_program;
      cmd(3'h5, 21'h5, 16'hBEEF);
      rd(21'h5, 16'hBEEF);
      cmd(3'h1, 21'h555, 16'h00AA);
      cmd(3'h1, 21'h2AA, 16'h0055);
      cmd(3'h1, 21'h123, 16'h0077);
      cmd(3'h1, 21'h5, 16'h1234);
      rd(21'h5, 16'hBEEF);
      cmd(3'h1, 21'h6, 16'h4321);
      rd(21'h6, 16'h1006);
   endtask
   task automatic t_autosel;
      cmd(3'h6, 21'h0, 16'h0000);
      rd(21'h0, 16'h005A);
      rd(21'h1, 16'h1357);
      cmd(3'h3, 21'h0, 16'h0000);
      rd(21'h0, 16'h1000);
      cmd(3'h5, 21'h7, 16'h0F0F);
      rd(21'h7, 16'h0F0F);
   endtask
   task automatic t_idread;
      cmd(3'h2, 21'h0, 16'h0000);
      check(rsp_data_out, 16'h005A);
      cmd(3'h2, 21'h1, 16'h0000);
      check(rsp_data_out, 16'h1357);
      check({15'h0000, rsp_locked_out}, 16'h0000);
      cmd(3'h2, 21'h3, 16'h0000);
      check({15'h0000, rsp_locked_out}, 16'h0001);
      check(rsp_data_out & 16'h0080, 16'h0080);
   endtask
   task automatic t_standby;
      cmd(3'h4, 21'h0, 16'h0000);
      check({15'h0000, chip_select_n_out}, 16'h0001);
      rd(21'h2, 16'h1002);
   endtask
   task automatic t_accel;
      accel_req_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      check({15'h0000, accel_program_pin_out}, 16'h0001);
      accel_req_in <= 1'b0;
   endtask
   initial begin
      repeat (5) @(posedge core_clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      t_array();
      t_program();
      t_autosel();
      t_idread();
      t_standby();
      t_accel();
      conclude();
   end
endmodule
`default_nettype wire
